/* rtl/output_nshot_mute_driver_cfg.sv */
// Notes on behaviour
// - With burst mode on, the output stays muted except during a requested burst, save OUTPUT_PAIR_A_N held high in mode 3; software sets the divider to 8 or more.
// - Bit 0 of the retime source register picks the pin or register trigger (0) or the internal retiming block (1).
// - Bypass bit 5 clear retimes the mute request to avoid runt pulses on OUTPUT_PAIR_A_P; set, the channel mutes at once.
// - Driver mode 0 is differential, 1 is dual single-ended from the primary divider, 2 is split primary/complementary.
// - Burst request mode starts one burst per trigger rising edge; gapped mode repeats bursts while the trigger is high.
// - Each burst carries exactly the number of OUTPUT_PAIR_A_P pulses in the six-bit count field.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module output_nshot_mute_driver_cfg (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire nshot_pkg::axil_req_t AXI_REQ,
   output var nshot_pkg::axil_rsp_t AXI_RSP,
   input wire logic PRIMARY_DIVIDER_A,
   input wire logic COMPLEMENTARY_DIVIDER_A,
   input wire logic MULTIFUNCTION_PINS,
   output logic OUTPUT_PAIR_A_P,
   output logic OUTPUT_PAIR_A_N
);

   typedef struct packed {
      nshot_pkg::axil_rsp_t rsp;
      logic aw_full;
      logic [15:0] aw_idx;
      logic w_full;
      logic [7:0] w_data;
      logic w_lane;
      logic [7:0] retime_src;
      logic [7:0] driver_a;
      logic [7:0] burst_ctrl;
      logic [7:0] chan_ctrl;
      logic [2:0] sp;
      logic [2:0] sn;
      logic [2:0] sm;
      logic div_p;
      logic div_n;
      logic pin_trig;
      logic int_trig;
      logic trig_old;
      logic pend;
      logic [5:0] rem;
      logic mute_eff;
      logic out_p;
      logic out_n;
   } state_t;

   state_t r_q, r_d;

   // Word index from a byte address
   function automatic logic [15:0] word_idx(input logic [31:0] addr);
      word_idx = addr[17:2];
   endfunction : word_idx

   // Synchroniser step: filtered level moves once the second and third stages agree
   function automatic logic filt(input logic [2:0] s, input logic old);
      filt = (s[1] == s[2]) ? s[2] : old;
   endfunction : filt

   logic ext_trig, trig, rise_p, fall_p, gate, burst_en, gapped, bypass;
   logic [1:0] mode;
   logic [7:0] rd_byte;
   logic rd_hit;

   // Register-derived controls and trigger source selection
   always_comb begin
      burst_en = r_q.burst_ctrl[nshot_pkg::NSHOT_EN_BIT];
      gapped = r_q.burst_ctrl[nshot_pkg::GAPPED_BIT];
      bypass = r_q.driver_a[nshot_pkg::BYPASS_BIT];
      mode = r_q.driver_a[nshot_pkg::MODE_LSB +: 2];
      ext_trig = r_q.chan_ctrl[nshot_pkg::PIN_SRC_BIT] ? r_q.pin_trig : r_q.chan_ctrl[nshot_pkg::SW_TRIG_BIT];
      trig = r_q.retime_src[nshot_pkg::RETIME_SEL_BIT] ? r_q.int_trig : ext_trig;
      rise_p = filt(r_q.sp, r_q.div_p) & ~r_q.div_p;
      fall_p = ~filt(r_q.sp, r_q.div_p) & r_q.div_p;
   end

   // Read mux; unlisted bits stay zero
   always_comb begin
      rd_hit = 1'b1;
      case (word_idx(AXI_REQ.araddr))
         nshot_pkg::IDX_RETIME_SRC: rd_byte = r_q.retime_src;
         nshot_pkg::IDX_DRIVER_A: rd_byte = r_q.driver_a;
         nshot_pkg::IDX_BURST_CTRL: rd_byte = r_q.burst_ctrl;
         nshot_pkg::IDX_CHAN_CTRL: rd_byte = r_q.chan_ctrl;
         nshot_pkg::IDX_STATUS: rd_byte = {4'h0, r_q.mute_eff, r_q.pend, r_q.rem != 6'h00, r_q.int_trig};
         default: begin
            rd_hit = 1'b0;
            rd_byte = 8'h00;
         end
      endcase
   end

   // Next-state logic for bus slave, synchronisers, burst engine and driver
   always_comb begin
      r_d = r_q;
      // Address and data are taken in either order; the response waits for both
      if (AXI_REQ.awvalid && r_q.rsp.awready) begin
         r_d.aw_full = 1'b1;
         r_d.aw_idx = word_idx(AXI_REQ.awaddr);
      end
      if (AXI_REQ.wvalid && r_q.rsp.wready) begin
         r_d.w_full = 1'b1;
         r_d.w_data = AXI_REQ.wdata[7:0];
         r_d.w_lane = AXI_REQ.wstrb[0];
      end
      if (r_q.rsp.bvalid && AXI_REQ.bready) begin
         r_d.rsp.bvalid = 1'b0;
      end
      if (r_d.aw_full && r_d.w_full && !r_d.rsp.bvalid) begin
         r_d.aw_full = 1'b0;
         r_d.w_full = 1'b0;
         r_d.rsp.bvalid = 1'b1;
         r_d.rsp.bresp = nshot_pkg::RESP_OKAY;
         case (r_d.aw_idx)
            nshot_pkg::IDX_RETIME_SRC: begin
               if (r_d.w_lane) r_d.retime_src = r_d.w_data & nshot_pkg::MASK_RETIME_SRC;
            end
            nshot_pkg::IDX_DRIVER_A: begin
               if (r_d.w_lane) r_d.driver_a = r_d.w_data & nshot_pkg::MASK_DRIVER_A;
            end
            nshot_pkg::IDX_BURST_CTRL: begin
               if (r_d.w_lane) r_d.burst_ctrl = r_d.w_data & nshot_pkg::MASK_BURST_CTRL;
            end
            nshot_pkg::IDX_CHAN_CTRL: begin
               if (r_d.w_lane) r_d.chan_ctrl = r_d.w_data & nshot_pkg::MASK_CHAN_CTRL;
            end
            nshot_pkg::IDX_STATUS: r_d.rsp.bresp = nshot_pkg::RESP_OKAY;
            default: r_d.rsp.bresp = nshot_pkg::RESP_SLVERR;
         endcase
      end
      r_d.rsp.awready = !r_d.aw_full && !r_d.rsp.bvalid;
      r_d.rsp.wready = !r_d.w_full && !r_d.rsp.bvalid;
      // Read: one outstanding, data registered with the accept
      if (r_q.rsp.rvalid && AXI_REQ.rready) begin
         r_d.rsp.rvalid = 1'b0;
      end
      if (AXI_REQ.arvalid && r_q.rsp.arready) begin
         r_d.rsp.rvalid = 1'b1;
         r_d.rsp.rdata = {24'h00_0000, rd_byte};
         r_d.rsp.rresp = rd_hit ? nshot_pkg::RESP_OKAY : nshot_pkg::RESP_SLVERR;
      end
      r_d.rsp.arready = !r_d.rsp.rvalid;
      // Three-stage synchronisers on pins from outside this clock
      r_d.sp = {r_q.sp[1:0], PRIMARY_DIVIDER_A};
      r_d.sn = {r_q.sn[1:0], COMPLEMENTARY_DIVIDER_A};
      r_d.sm = {r_q.sm[1:0], MULTIFUNCTION_PINS};
      r_d.div_p = filt(r_q.sp, r_q.div_p);
      r_d.div_n = filt(r_q.sn, r_q.div_n);
      r_d.pin_trig = filt(r_q.sm, r_q.pin_trig);
      // Internal retiming block: trigger sampled on the divider falling edge
      if (fall_p) r_d.int_trig = ext_trig;
      // Trigger turns into a pending request; set wins over the consume below
      r_d.trig_old = trig;
      if (gapped ? trig : (trig && !r_q.trig_old)) r_d.pend = 1'b1;
      // A burst loads only while the divider is low, so its first pulse is whole
      if (r_q.pend && !r_d.div_p && r_q.rem == 6'h00 && !rise_p) begin
         r_d.rem = r_q.burst_ctrl[nshot_pkg::COUNT_LSB +: 6];
         r_d.pend = gapped ? trig : (trig && !r_q.trig_old);
      end else if (fall_p && r_q.rem != 6'h00) begin
         r_d.rem = r_q.rem - 6'h01;
      end
      if (!burst_en) begin
         r_d.rem = nshot_pkg::RST_COUNT;
         r_d.pend = 1'b0;
      end
      // Mute follows the request at once, or only while the divider is low
      if (bypass || !r_d.div_p) r_d.mute_eff = r_q.chan_ctrl[nshot_pkg::MUTE_REQ_BIT];
      // Gate stays shut between bursts when burst mode is on
      gate = (!burst_en || r_d.rem != 6'h00) && !r_d.mute_eff;
      r_d.out_p = r_d.div_p && gate;
      case (mode)
         nshot_pkg::MODE_DIFF: r_d.out_n = !r_d.out_p;
         nshot_pkg::MODE_SE_SAME: r_d.out_n = r_d.out_p;
         nshot_pkg::MODE_SE_SPLIT: r_d.out_n = r_d.div_n && gate;
         default: r_d.out_n = !r_d.out_p;
      endcase
      if (!gate && mode == nshot_pkg::MODE_DIFF) r_d.out_n = 1'b0;
   end

   // State register
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign AXI_RSP = r_q.rsp;
   assign OUTPUT_PAIR_A_P = r_q.out_p;
   assign OUTPUT_PAIR_A_N = r_q.out_n;

   // Checks on the driven behaviour
   a_idle_gate_shut: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      ($past(burst_en) && burst_en && r_q.rem == 6'h00) |-> !OUTPUT_PAIR_A_P)
      else $error("Output pulsed outside a burst");

   a_source_select: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (!gapped && $past(!gapped) && $rose(trig)) |=> r_q.pend || !burst_en || r_q.rem != 6'h00)
      else $error("Selected trigger source did not raise a request");

   a_mute_bypass: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (bypass && r_q.chan_ctrl[nshot_pkg::MUTE_REQ_BIT]) |=> !OUTPUT_PAIR_A_P)
      else $error("Bypassed mute did not act at once");

   a_mute_retimed: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      ($rose(r_q.mute_eff) && !$past(bypass)) |-> !r_q.div_p)
      else $error("Retimed mute changed while divider high");

   a_mode_routing: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      ($past(mode) == nshot_pkg::MODE_SE_SAME) |-> OUTPUT_PAIR_A_N == OUTPUT_PAIR_A_P)
      else $error("Dual single-ended mode not copying primary");

   a_gapped_repeat: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (gapped && trig && burst_en) |=> r_q.pend || r_q.rem != 6'h00 || !burst_en || !gapped)
      else $error("Gapped mode stopped while trigger high");

   a_burst_load: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      ($past(r_q.rem) == 6'h00 && r_q.rem != 6'h00) |-> r_q.rem == $past(r_q.burst_ctrl[5:0]))
      else $error("Burst loaded with wrong count");

   a_reserved_zero: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      r_q.rsp.rvalid |-> r_q.rsp.rdata[31:8] == 24'h00_0000 && r_q.driver_a[7:6] == 2'h0 && r_q.retime_src[7:1] == 7'h00)
      else $error("Reserved bits not zero");

endmodule : output_nshot_mute_driver_cfg
`default_nettype wire

/* rtl/nshot_pkg.sv */
package nshot_pkg;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_RETIME_SRC = 16'h14d6;
   localparam logic [15:0] IDX_DRIVER_A = 16'h14d7;
   localparam logic [15:0] IDX_BURST_CTRL = 16'h14e0;
   localparam logic [15:0] IDX_CHAN_CTRL = 16'h14e1;
   localparam logic [15:0] IDX_STATUS = 16'h14e2;

   // Field positions
   localparam int RETIME_SEL_BIT = 0;
   localparam int BYPASS_BIT = 5;
   localparam int MODE_LSB = 3;
   localparam int COUNT_LSB = 0;
   localparam int GAPPED_BIT = 6;
   localparam int NSHOT_EN_BIT = 7;
   localparam int MUTE_REQ_BIT = 0;
   localparam int SW_TRIG_BIT = 1;
   localparam int PIN_SRC_BIT = 2;

   // Writable masks keep reserved bits at zero
   localparam logic [7:0] MASK_RETIME_SRC = 8'h01;
   localparam logic [7:0] MASK_DRIVER_A = 8'h3f;
   localparam logic [7:0] MASK_BURST_CTRL = 8'hff;
   localparam logic [7:0] MASK_CHAN_CTRL = 8'h07;

   // Reset values
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [2:0] RST_SYNC = 3'h0;
   localparam logic [5:0] RST_COUNT = 6'h00;

   // Driver modes
   localparam logic [1:0] MODE_DIFF = 2'h0;
   localparam logic [1:0] MODE_SE_SAME = 2'h1;
   localparam logic [1:0] MODE_SE_SPLIT = 2'h2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;

endpackage : nshot_pkg

/* dv/divider_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Free-running divider pair and trigger pin feeding the output channel
module divider_model (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic trig,
   output logic prim,
   output logic comp,
   output logic pin
);
   logic [3:0] cnt_q;
   // Ratio 10 keeps both dividers above the minimum of 8
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
      end
   end
   // Same ratio; complement lags a fifth so split routing is visible
   assign prim = (cnt_q < 4'h5);
   assign comp = (cnt_q >= 4'h2) && (cnt_q < 4'h7);
   assign pin = trig;
endmodule : divider_model
`default_nettype wire

/* dv/output_nshot_mute_driver_cfg_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module output_nshot_mute_driver_cfg_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic trig = 1'b0;
   logic prim, comp, pin, out_p, out_n;
   nshot_pkg::axil_req_t req = '0;
   nshot_pkg::axil_rsp_t rsp;
   int fail_count = 0;
   int cmp_count = 0;
   int ones, eq, p0, r0;
   int pulses = 0;
   int runts = 0;
   int hi = -1;
   logic [31:0] rd;
   logic [1:0] resp;

   always #2 clk = ~clk;

   divider_model partner (.CLOCK(clk), .SYS_RST(rst), .trig(trig), .prim(prim), .comp(comp), .pin(pin));
   output_nshot_mute_driver_cfg DUT (.CLOCK(clk), .SYS_RST(rst), .AXI_REQ(req), .AXI_RSP(rsp),
      .PRIMARY_DIVIDER_A(prim), .COMPLEMENTARY_DIVIDER_A(comp), .MULTIFUNCTION_PINS(pin),
      .OUTPUT_PAIR_A_P(out_p), .OUTPUT_PAIR_A_N(out_n));

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      req.awaddr <= {14'h0000, idx, 2'h0};
      req.wdata <= {24'h00_0000, d};
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      resp = rsp.bresp;
   endtask : wr

   task automatic rdreg(input logic [15:0] idx);
      req.araddr <= {14'h0000, idx, 2'h0};
      req.arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      rd = rsp.rdata;
      resp = rsp.rresp;
   endtask : rdreg

   task automatic watch(input int n);
      ones = 0;
      eq = 0;
      repeat (n) begin
         @(posedge clk);
         ones += (out_p === 1'b1);
         eq += (out_p === out_n);
      end
   endtask : watch

   // Pulse tally; a pulse already running when counting starts is ignored
   always @(posedge clk) begin
      if (out_p !== 1'b1) begin
         if (hi > 0) pulses++;
         if (hi > 0 && hi < 5) runts++;
         hi = 0;
      end else if (hi >= 0) hi++;
   end

   // Hang guard, far beyond the roughly 1000 cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      end_of_test();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // Response ready stays high, so back-to-back calls never toggle it in one step
      req.bready <= 1'b1;
      req.rready <= 1'b1;
      @(posedge clk);
      // Reset values, reserved bits and an unmapped word
      rdreg(nshot_pkg::IDX_RETIME_SRC);
      check("retime_rst", 0, rd);
      rdreg(nshot_pkg::IDX_DRIVER_A);
      check("driver_rst", 0, rd);
      wr(nshot_pkg::IDX_RETIME_SRC, 8'hff);
      check("wr_okay", 32'(nshot_pkg::RESP_OKAY), 32'(resp));
      rdreg(nshot_pkg::IDX_RETIME_SRC);
      check("retime_rb", 32'h0000_0001, rd);
      wr(nshot_pkg::IDX_DRIVER_A, 8'hff);
      rdreg(nshot_pkg::IDX_DRIVER_A);
      check("driver_rb", 32'h0000_003f, rd);
      rdreg(16'h14d5);
      check("unmapped", 32'(nshot_pkg::RESP_SLVERR), 32'(resp));
      wr(16'h14d5, 8'h55);
      check("wr_unmapped", 32'(nshot_pkg::RESP_SLVERR), 32'(resp));
      wr(nshot_pkg::IDX_RETIME_SRC, 8'h00);
      // Every routing mode; six whole periods give 30 high samples
      for (int m = 0; m < 3; m++) begin
         wr(nshot_pkg::IDX_DRIVER_A, {3'h0, 2'(m), 3'h0});
         watch(20);
         watch(60);
         check("duty", 30, ones);
         check("p_eq_n", (m == 0) ? 0 : (m == 1) ? 60 : 36, eq);
      end
      // Muted until a register trigger asks for one burst of three
      wr(nshot_pkg::IDX_BURST_CTRL, 8'h83);
      watch(20);
      watch(40);
      check("idle_mute", 0, ones);
      p0 = pulses;
      r0 = runts;
      wr(nshot_pkg::IDX_CHAN_CTRL, 8'h02);
      watch(100);
      check("burst_len", 3, pulses - p0);
      watch(60);
      check("one_burst", 3, pulses - p0);
      check("burst_runt", r0, runts);
      // Pin trigger through the retiming block, bursts repeat while high
      wr(nshot_pkg::IDX_CHAN_CTRL, 8'h04);
      wr(nshot_pkg::IDX_RETIME_SRC, 8'h01);
      wr(nshot_pkg::IDX_BURST_CTRL, 8'hc3);
      p0 = pulses;
      trig <= 1'b1;
      watch(150);
      check("gapped", 1, 32'((pulses - p0) > 3));
      trig <= 1'b0;
      // A request latched before the trigger fell may still run one more burst
      watch(100);
      p0 = pulses;
      watch(60);
      check("gap_stop", p0, pulses);
      // Retimed mute must not chop a pulse; bypassed mute acts at once
      wr(nshot_pkg::IDX_BURST_CTRL, 8'h00);
      wr(nshot_pkg::IDX_DRIVER_A, 8'h08);
      wr(nshot_pkg::IDX_CHAN_CTRL, 8'h00);
      watch(20);
      r0 = runts;
      wr(nshot_pkg::IDX_CHAN_CTRL, 8'h01);
      watch(30);
      check("mute_runt", r0, runts);
      watch(30);
      check("muted", 0, ones);
      wr(nshot_pkg::IDX_CHAN_CTRL, 8'h00);
      wr(nshot_pkg::IDX_DRIVER_A, 8'h28);
      watch(20);
      wr(nshot_pkg::IDX_CHAN_CTRL, 8'h01);
      watch(2);
      watch(10);
      check("mute_now", 0, ones);
      // Status shows mute in effect, nothing pending or running
      rdreg(nshot_pkg::IDX_STATUS);
      check("status", 32'h0000_0008, rd);
      end_of_test();
   end
endmodule : output_nshot_mute_driver_cfg_tb
`default_nettype wire
